//--- design/gp_event_pkg.sv
// Package: register map, field layout and carriers for the event and expander address bank
package gp_event_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PORTS     = 16;
  localparam int NUM_EXPANDERS = 14;
  localparam int ADDR_W        = 7;
  localparam int SLOTS_PER_REG = 4;
  localparam int NUM_ADDR_REGS = 4;
  localparam int PADDR_W       = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [PADDR_W-1:0] EXPANDER_ADDRESS_GROUP0 = 12'h0ad8;
  localparam logic [PADDR_W-1:0] EXPANDER_ADDRESS_GROUP1 = 12'h0adc;
  localparam logic [PADDR_W-1:0] EXPANDER_ADDRESS_GROUP2 = 12'h0ae0;
  localparam logic [PADDR_W-1:0] EXPANDER_ADDRESS_GROUP3 = 12'h0ae4;
  localparam logic [PADDR_W-1:0] GP_EVENT_CONTROL        = 12'h0ae8;
  localparam logic [PADDR_W-1:0] GP_EVENT_STATUS         = 12'h0aec;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int SLOT_STRIDE   = 8;
  localparam int SLOT_LSB      = 1;
  localparam int POLARITY_BIT  = 31;
  // Writable bits of each address register; the last one holds two slots only
  localparam logic [31:0] ADDR_FULL_MASK = 32'hfefe_fefe;
  localparam logic [31:0] ADDR_LAST_MASK = 32'h0000_fefe;
  localparam logic [31:0] CONTROL_MASK   = 32'h8000_ffff;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [PADDR_W-1:0]      paddr;
    logic [31:0]             pwdata;
  } apb_req_s;

  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [NUM_PORTS-1:0]    hotplug_intx;
    logic [NUM_PORTS-1:0]    msi;
    logic [NUM_PORTS-1:0]    pme;
  } port_notify_s;

endpackage

//--- design/port_event_lane.sv
// One port's event reroute, status and polarity lane
`timescale 1ns/100ps
`default_nettype none
module port_event_lane
  import gp_event_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic reroute_enable,
  input  wire logic polarity_invert,
  // Notifications from the port
  input  wire logic hotplug_intx_req,
  input  wire logic msi_req,
  input  wire logic pme_req,
  // Results
  output logic      hotplug_intx_out,
  output logic      msi_out,
  output logic      pme_out,
  output logic      active_status,
  output logic      event_pin
);

  logic pending;
  logic next_status;

  assign pending          = hotplug_intx_req | msi_req | pme_req;
  // Standard paths muted while rerouted
  assign hotplug_intx_out = hotplug_intx_req & ~reroute_enable;
  assign msi_out          = msi_req & ~reroute_enable;
  assign pme_out          = pme_req & ~reroute_enable;
  assign next_status      = reroute_enable & pending;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      active_status <= 1'b0;
    else
      active_status <= next_status;
  end

  // Idle level follows polarity: active low unless inverted
  assign event_pin = polarity_invert ? active_status : ~active_status;

endmodule
`default_nettype wire

//--- design/gp_event_regs.sv
// APB register bank: expander addresses and general purpose event control/status
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module gp_event_regs
  import gp_event_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // APB slave
  input  wire gp_event_pkg::apb_req_s apb_req,
  output gp_event_pkg::apb_rsp_s      apb_rsp,
  // Port notifications in and standard paths out
  input  wire gp_event_pkg::port_notify_s notify_in,
  output gp_event_pkg::port_notify_s  notify_out,
  // GPIO alternate function for event signals
  output logic [gp_event_pkg::NUM_PORTS-1:0] gpio_alt_event,
  output logic [gp_event_pkg::NUM_PORTS-1:0] gpio_alt_event_oe,
  // Expander addresses to the master SMBus engine
  output logic [gp_event_pkg::NUM_EXPANDERS*gp_event_pkg::ADDR_W-1:0] expander_address
);
  import gp_event_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0]          addr_reg [NUM_ADDR_REGS];
  logic [NUM_PORTS-1:0] port_event_reroute_enable;
  logic                 event_signal_polarity_invert;
  logic [NUM_PORTS-1:0] port_event_active_status;
  logic [NUM_PORTS-1:0] gp_event_signal;
  logic [31:0]          prdata;

  // ****************************************
  // Decode
  // ****************************************
  wire       access    = apb_req.psel & apb_req.penable;
  wire       wr_en     = access & apb_req.pwrite;
  wire       sel_a0    = apb_req.paddr == EXPANDER_ADDRESS_GROUP0;
  wire       sel_a1    = apb_req.paddr == EXPANDER_ADDRESS_GROUP1;
  wire       sel_a2    = apb_req.paddr == EXPANDER_ADDRESS_GROUP2;
  wire       sel_a3    = apb_req.paddr == EXPANDER_ADDRESS_GROUP3;
  wire       sel_ctl   = apb_req.paddr == GP_EVENT_CONTROL;
  wire       sel_sts   = apb_req.paddr == GP_EVENT_STATUS;
  wire       mapped    = sel_a0 | sel_a1 | sel_a2 | sel_a3 | sel_ctl | sel_sts;
  wire [1:0] addr_idx  = sel_a0 ? 2'd0 : sel_a1 ? 2'd1 : sel_a2 ? 2'd2 : 2'd3;
  wire       addr_hit  = sel_a0 | sel_a1 | sel_a2 | sel_a3;
  wire [31:0] addr_mask = sel_a3 ? ADDR_LAST_MASK : ADDR_FULL_MASK;
  wire [31:0] status_word = {{(32-NUM_PORTS){1'b0}}, port_event_active_status};
  wire [31:0] control_word = {event_signal_polarity_invert, {(31-NUM_PORTS){1'b0}},
                              port_event_reroute_enable};
  wire [31:0] next_rdata;

  // Zero-wait slave; unmapped offsets answer with an error and read zero
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access & ~mapped;
  assign apb_rsp.prdata  = prdata;

  assign next_rdata = addr_hit ? (addr_reg[addr_idx] & addr_mask) :
                      sel_ctl  ? control_word :
                      sel_sts  ? status_word : RESET_VALUE;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_ADDR_REGS; i++)
        addr_reg[i] <= RESET_VALUE;
    end
    else if (wr_en && addr_hit)
      addr_reg[addr_idx] <= apb_req.pwdata & addr_mask;
  end

  // Status register has no write path at all
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_event_reroute_enable    <= RESET_VALUE[NUM_PORTS-1:0];
      event_signal_polarity_invert <= 1'b0;
    end
    else if (wr_en && sel_ctl)
    begin
      port_event_reroute_enable    <= apb_req.pwdata[NUM_PORTS-1:0];
      event_signal_polarity_invert <= apb_req.pwdata[POLARITY_BIT];
    end
  end

  // Read data held in flops; combinational mux feeds them during setup
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= RESET_VALUE;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      prdata <= next_rdata;
  end

  // ****************************************
  // Expander address fan-out
  // ****************************************
  genvar e;
  generate
    for (e = 0; e < NUM_EXPANDERS; e++)
    begin : g_exp
      assign expander_address[e*ADDR_W +: ADDR_W] =
        addr_reg[e / SLOTS_PER_REG][(e % SLOTS_PER_REG)*SLOT_STRIDE + SLOT_LSB +: ADDR_W];
    end
  endgenerate

  // ****************************************
  // Per-port event lanes
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      port_event_lane u_lane
      (
        .sys_clk          (sys_clk),
        .rst_b            (rst_b),
        .reroute_enable   (port_event_reroute_enable[p]),
        .polarity_invert  (event_signal_polarity_invert),
        .hotplug_intx_req (notify_in.hotplug_intx[p]),
        .msi_req          (notify_in.msi[p]),
        .pme_req          (notify_in.pme[p]),
        .hotplug_intx_out (notify_out.hotplug_intx[p]),
        .msi_out          (notify_out.msi[p]),
        .pme_out          (notify_out.pme[p]),
        .active_status    (port_event_active_status[p]),
        .event_pin        (gp_event_signal[p])
      );
    end
  endgenerate

  // Alternate function drive; GPIO mux picks it when the pin is so configured
  assign gpio_alt_event    = gp_event_signal;
  assign gpio_alt_event_oe = port_event_reroute_enable;

  // ****************************************
  // Checks
  // ****************************************
  sequence ctl_write_s;
    wr_en && sel_ctl;
  endsequence

  addr_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && sel_a0) |=> expander_address[ADDR_W-1:0] == $past(apb_req.pwdata[SLOT_LSB +: ADDR_W]))
    else $error("expander 0 address not stored");

  last_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (addr_reg[NUM_ADDR_REGS-1] & ~ADDR_LAST_MASK) == RESET_VALUE)
    else $error("unused upper slots of last address word set");

  mute_std_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (notify_out.msi & port_event_reroute_enable) == '0)
    else $error("msi passed while port rerouted");

  enable_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctl_write_s |=> port_event_reroute_enable == $past(apb_req.pwdata[NUM_PORTS-1:0]))
    else $error("enable vector not written");

  polarity_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    gp_event_signal == (event_signal_polarity_invert ? port_event_active_status
                                                      : ~port_event_active_status))
    else $error("event signal polarity wrong");

  status_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 port_event_active_status == $past(port_event_reroute_enable &
      (notify_in.hotplug_intx | notify_in.msi | notify_in.pme)))
    else $error("status does not track pending events");

  // Status lags the enable by one flop, so compare against last cycle's enable
  status_gated_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 (port_event_active_status & ~$past(port_event_reroute_enable)) == '0)
    else $error("status set while disabled");

  status_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && sel_sts) |=> $stable(port_event_reroute_enable) &&
      port_event_active_status == $past(port_event_reroute_enable &
      (notify_in.hotplug_intx | notify_in.msi | notify_in.pme)))
    else $error("status affected by write");

  alt_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    gpio_alt_event_oe == port_event_reroute_enable)
    else $error("alternate function enable wrong");

endmodule
`default_nettype wire

//--- verif/port_notify_model.sv
// Port notification source standing beside the event bank
`timescale 1ns/100ps
`default_nettype none
module port_notify_model
  import gp_event_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // Requests wanted by the test
  input  wire gp_event_pkg::port_notify_s want,
  // Levels seen by the bank
  output gp_event_pkg::port_notify_s      notify
);
  // Ports move their request levels only after an edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      notify <= '0;
    else
      notify <= want;
  end
endmodule
`default_nettype wire

//--- verif/test_gp_event_and_expander_address_regs.sv
// Testbench for the event and expander address register bank
`timescale 1ns/100ps
`default_nettype none
module test_gp_event_and_expander_address_regs;
  import gp_event_pkg::*;
  localparam int W = NUM_EXPANDERS*ADDR_W;
  logic         sys_clk;
  logic         rst_b;
  apb_req_s     apb_req;
  apb_rsp_s     apb_rsp;
  port_notify_s want;
  port_notify_s notify_in;
  port_notify_s notify_out;
  logic [15:0]  gpio_alt_event;
  logic [15:0]  gpio_alt_event_oe;
  logic [W-1:0] expander_address;
  logic [W-1:0] exp_addr;
  logic [31:0]  rd;
  logic [31:0]  wv [NUM_ADDR_REGS];
  logic         err;
  int           n_errors;
  int           n_compared;

  gp_event_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .notify_in(notify_in), .notify_out(notify_out), .gpio_alt_event(gpio_alt_event),
    .gpio_alt_event_oe(gpio_alt_event_oe), .expander_address(expander_address));
  port_notify_model ports (.sys_clk(sys_clk), .rst_b(rst_b), .want(want), .notify(notify_in));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for pready, never assumes a wait count
  task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    rst_b = 1'b0;
    apb_req = '0;
    want = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    check(W'(gpio_alt_event), W'(16'hffff));
    check(W'(gpio_alt_event_oe), '0);
    for (int r = 0; r < 6; r++)
    begin
      apb(1'b0, EXPANDER_ADDRESS_GROUP0 + PADDR_W'(4*r), '0);
      check(W'({err, rd}), W'({1'b0, RESET_VALUE}));
    end
    // Reserved bits are set on purpose in every pattern
    for (int r = 0; r < NUM_ADDR_REGS; r++)
    begin
      wv[r] = 32'hf1e3_a5c7 ^ {4{8'(r << 2)}};
      apb(1'b1, EXPANDER_ADDRESS_GROUP0 + PADDR_W'(4*r), wv[r]);
    end
    for (int r = 0; r < NUM_ADDR_REGS; r++)
    begin
      apb(1'b0, EXPANDER_ADDRESS_GROUP0 + PADDR_W'(4*r), '0);
      check(W'(rd), W'(wv[r] & (r == 3 ? ADDR_LAST_MASK : ADDR_FULL_MASK)));
    end
    for (int e = 0; e < NUM_EXPANDERS; e++)
      exp_addr[ADDR_W*e +: ADDR_W] = wv[e/4][SLOT_STRIDE*(e%4) + SLOT_LSB +: ADDR_W];
    check(expander_address, exp_addr);
    apb(1'b0, 12'h0af0, '0);
    check(W'({err, rd}), W'({1'b1, 32'h0}));
    // Unmapped write answers with an error and must not land anywhere
    apb(1'b1, 12'h0af0, 32'hffff_ffff);
    check(W'(err), W'(1'b1));
    apb(1'b0, EXPANDER_ADDRESS_GROUP0, '0);
    check(W'(rd), W'(wv[0] & ADDR_FULL_MASK));
    apb(1'b1, GP_EVENT_CONTROL, 32'hffff_ffff);
    apb(1'b0, GP_EVENT_CONTROL, '0);
    check(W'({err, rd}), W'({1'b0, CONTROL_MASK}));
    // Port 3 rerouted, port 5 left on the standard paths
    apb(1'b1, GP_EVENT_CONTROL, 32'h0000_0008);
    want <= '{hotplug_intx: 16'h0008, msi: 16'h0028, pme: 16'h0008};
    settle();
    check(W'(gpio_alt_event_oe), W'(16'h0008));
    check(W'(notify_out), W'({16'h0000, 16'h0020, 16'h0000}));
    check(W'(gpio_alt_event), W'(16'hfff7));
    apb(1'b1, GP_EVENT_STATUS, 32'hffff_ffff);
    check(W'(err), '0);
    apb(1'b0, GP_EVENT_STATUS, '0);
    check(W'(rd), W'(32'h0000_0008));
    apb(1'b1, GP_EVENT_CONTROL, 32'h8000_0008);
    settle();
    check(W'(gpio_alt_event), W'(16'h0008));
    want <= '0;
    settle();
    check(W'(gpio_alt_event), '0);
    apb(1'b0, GP_EVENT_STATUS, '0);
    check(W'(rd), '0);
    summarize();
  end
endmodule
`default_nettype wire
